// *** hdl/ofd_pkg.sv ***
// operand field decoder package: register map, field layout, forms, timing
// assumes a 32-bit classic wishbone bus and a 100 MHz core clock
package ofd_pkg;

    // ------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_INSTR = 8'h00;
    localparam logic [7:0] OFS_FORM  = 8'h04;
    localparam logic [7:0] OFS_WACC  = 8'h08;
    localparam logic [7:0] OFS_BANK  = 8'h0C;
    localparam logic [7:0] OFS_STAT  = 8'h10;
    localparam logic [7:0] OFS_TPTR  = 8'h14;
    localparam logic [7:0] OFS_TLAT  = 8'h18;
    localparam logic [7:0] OFS_PTR   = 8'h1C;
    localparam logic [7:0] OFS_DADDR = 8'h20;
    localparam logic [7:0] OFS_MOVE  = 8'h24;
    localparam logic [7:0] OFS_LIT   = 8'h28;
    localparam logic [7:0] OFS_TGT   = 8'h2C;
    localparam logic [7:0] OFS_DECST = 8'h30;

    // ------------------------------------------------------------
    // widths, constants and reset values
    // ------------------------------------------------------------
    localparam int         TPTR_W       = 21;
    localparam int         FADDR_W      = 12;
    localparam logic [3:0] ACCESS_BANK  = 4'h0;
    localparam logic [3:0] SECOND_MARK  = 4'hF;
    localparam logic [1:0] CYC_ONE      = 2'h1;
    localparam logic [1:0] CYC_TWO      = 2'h2;
    localparam int         OSC_PER_CYC  = 4;
    localparam int         CLK_MHZ      = 100;
    localparam logic [4:0] STAT_RESET   = 5'h00;

    // status flag positions
    localparam int FLG_C  = 0;
    localparam int FLG_HC = 1;
    localparam int FLG_Z  = 2;
    localparam int FLG_OVF = 3;
    localparam int FLG_N  = 4;

    // ------------------------------------------------------------
    // instruction forms, literal widths, table step modes
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        FM_BYTE, FM_BIT, FM_LIT8, FM_LIT12, FM_MOVE, FM_IDXMOVE,
        FM_TABLE, FM_REL8, FM_REL11, FM_ABS, FM_CALL, FM_RET
    } ofd_form_e;

    typedef enum logic [1:0] {LW_8, LW_12, LW_20} ofd_litw_e;

    typedef enum logic [1:0] {
        TS_NONE, TS_POSTINC, TS_POSTDEC, TS_PREINC
    } ofd_step_e;

endpackage : ofd_pkg

// *** hdl/ofd_tbl_step.sv ***
// table pointer step unit: access address and next pointer for one access
// assumes the caller applies next_ptr only when a table access executes
`timescale 1ns/100ps
module ofd_tbl_step
    import ofd_pkg::*;
#(
    parameter int PW = TPTR_W
) (
    // pointer in
    input  wire logic [PW-1:0] ptr,
    input  wire logic [1:0]    mode,
    // results
    output logic      [PW-1:0] access_addr,
    output logic      [PW-1:0] next_ptr
);

    wire [PW-1:0] ptr_inc = ptr + PW'(1);
    wire [PW-1:0] ptr_dec = ptr - PW'(1);

    // pre-increment uses the stepped value for the access itself
    assign access_addr = (mode == TS_PREINC) ? ptr_inc : ptr;
    assign next_ptr    = (mode == TS_NONE)    ? ptr     :
                         (mode == TS_POSTDEC) ? ptr_dec : ptr_inc;

endmodule : ofd_tbl_step

// *** hdl/ofd_field_dec.sv ***
// operand field extractor: splits one or two instruction words by form
// assumes the form is chosen by software, not derived from opcode bits
`timescale 1ns/100ps
module ofd_field_dec
    import ofd_pkg::*;
(
    // words
    input  wire logic [3:0]  form,
    input  wire logic [15:0] w1,
    input  wire logic [15:0] w2,
    // byte and bit operands
    output logic      [7:0]  f8,
    output logic      [1:0]  ptr_sel,
    output logic             access_sel,
    output logic             to_file,
    output logic      [2:0]  bit_idx,
    // move operands
    output logic      [11:0] src_adr,
    output logic      [11:0] dst_adr,
    output logic      [6:0]  src_off,
    output logic      [6:0]  dst_off,
    // literal, table, program address
    output logic      [19:0] lit,
    output logic      [1:0]  lit_w,
    output logic      [1:0]  step,
    output logic      [20:0] target,
    output logic             rel,
    output logic             fast,
    output logic             two_word,
    output logic             pc_change
);

    // bits not named below are never looked at (see RULE11)
    assign f8         = w1[7:0];                      // see RULE4
    assign ptr_sel    = w1[5:4];                      // see RULE4
    assign access_sel = w1[8];
    assign to_file    = w1[9];
    assign bit_idx    = w1[11:9];                     // see RULE2
    assign src_adr    = w1[11:0];                     // see RULE5
    assign dst_adr    = w2[11:0];                     // see RULE5
    assign src_off    = w1[6:0];                      // see RULE12
    assign dst_off    = w2[6:0];                      // see RULE12
    assign step       = w1[1:0];                      // see RULE7
    assign fast       = (form == FM_RET) ? w1[0] : w1[8];   // see RULE10

    // literal width follows the form (see RULE6)
    assign lit   = (form == FM_LIT12) ? {8'h00, w1[3:0], w2[7:0]} :
                   (form == FM_ABS || form == FM_CALL) ? {w2[11:0], w1[7:0]} :
                   {12'h000, w1[7:0]};
    assign lit_w = (form == FM_LIT12) ? LW_12 :
                   (form == FM_ABS || form == FM_CALL) ? LW_20 : LW_8;

    // relative forms sign-extend, absolute forms zero-extend (see RULE9)
    assign rel    = (form == FM_REL8) || (form == FM_REL11);
    assign target = (form == FM_REL8)  ? {{13{w1[7]}}, w1[7:0]}  :
                    (form == FM_REL11) ? {{10{w1[10]}}, w1[10:0]} :
                    {1'b0, w2[11:0], w1[7:0]};

    assign two_word  = (form == FM_LIT12) || (form == FM_MOVE) ||
                       (form == FM_IDXMOVE) || (form == FM_ABS) || (form == FM_CALL);
    assign pc_change = rel || (form == FM_ABS) || (form == FM_CALL) || (form == FM_RET);

endmodule : ofd_field_dec

// *** hdl/ofd_top.sv ***
// operand field decoder with wishbone register access
// assumes a classic wishbone master, 32-bit data, byte addresses
// Behaviour
// RULE1: access bit picks quick region or bank
// RULE2: three-bit index selects one of eight bits
// RULE3: destination bit picks accumulator or file
// RULE4: short field is address or pointer select
// RULE5: moves decode two twelve-bit full addresses
// RULE6: literal is eight, twelve or twenty bits
// RULE7: table access steps pointer per mode
// RULE8: hold 21-bit table pointer, 8-bit latch
// RULE9: relative displacement signed, absolute target plain
// RULE10: fast bit saves and restores shadow copies
// RULE11: don't-care bits never change behaviour
// RULE12: indexed moves use seven-bit source/target offsets
// RULE13: keep carry, half carry, zero, overflow, negative
// RULE14: second word needs top ones; alone is nop
// RULE15: cycle is four clocks; one or two cycles
//
// The address map and the Wishbone register port are this design's own decisions.
`timescale 1ns/100ps
module ofd_top
    import ofd_pkg::*;
#(
    parameter int BANK_W = 4
) (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // wishbone slave
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [31:0] wb_dat_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic        wb_we_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // decoded controls to the data path
    output logic      [11:0] file_addr,
    output logic      [7:0]  bit_mask,
    output logic             to_file,
    output logic      [20:0] table_access,
    output logic             exec_pulse
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [15:0]       first_word;
    logic [15:0]       last_word;
    logic              pending;
    logic [3:0]        form;
    logic [7:0]        working_accumulator;
    logic [BANK_W-1:0] bank_selector;
    logic [4:0]        status_flags;
    logic [TPTR_W-1:0] table_pointer;
    logic [7:0]        table_latch;
    logic [11:0]       indirect_pointer;
    logic [7:0]        sh_acc;
    logic [BANK_W-1:0] sh_bank;
    logic [4:0]        sh_flags;
    logic [1:0]        ptr_sel_q;
    logic [11:0]       move_source_address;
    logic [11:0]       move_target_address;
    logic [19:0]       lit_q;
    logic [1:0]        lit_w_q;
    logic [20:0]       target_q;
    logic              rel_q;
    logic [1:0]        cycles;
    logic              nop_q;
    logic              pair_err;

    // ------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------
    function automatic logic [31:0] merge(input logic [31:0] old_v,
                                          input logic [31:0] new_v,
                                          input logic [3:0]  sel);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                r[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return r;
    endfunction : merge

    wire bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire wr      = bus_req && wb_we_i;
    wire rd      = bus_req && !wb_we_i;

    function automatic logic hit(input logic [7:0] adr, input logic [7:0] ofs);
        return wr && (adr == ofs);
    endfunction : hit

    wire wr_instr = hit(wb_adr_i, OFS_INSTR) && (wb_sel_i[1:0] == 2'h3);
    wire [15:0] word_in = wb_dat_i[15:0];

    // ------------------------------------------------------------
    // field extraction and table step
    // ------------------------------------------------------------
    wire        fwd_two = (form == FM_LIT12) || (form == FM_MOVE) ||
                          (form == FM_IDXMOVE) || (form == FM_ABS) || (form == FM_CALL);
    wire [15:0] w1 = pending ? first_word : word_in;
    logic [7:0]  d_f8;
    logic [1:0]  d_ptr;
    logic        d_acc;
    logic        d_to_file;
    logic [2:0]  d_bit;
    logic [11:0] d_src_adr;
    logic [11:0] d_dst_adr;
    logic [6:0]  d_src_off;
    logic [6:0]  d_dst_off;
    logic [19:0] d_lit;
    logic [1:0]  d_lit_w;
    logic [1:0]  d_step;
    logic [20:0] d_target;
    logic        d_rel;
    logic        d_fast;
    logic        d_two;
    logic        d_pcc;
    logic [20:0] t_access;
    logic [20:0] t_next;

    ofd_field_dec u_dec (
        .form      (form),
        .w1        (w1),
        .w2        (word_in),
        .f8        (d_f8),
        .ptr_sel   (d_ptr),
        .access_sel(d_acc),
        .to_file   (d_to_file),
        .bit_idx   (d_bit),
        .src_adr   (d_src_adr),
        .dst_adr   (d_dst_adr),
        .src_off   (d_src_off),
        .dst_off   (d_dst_off),
        .lit       (d_lit),
        .lit_w     (d_lit_w),
        .step      (d_step),
        .target    (d_target),
        .rel       (d_rel),
        .fast      (d_fast),
        .two_word  (d_two),
        .pc_change (d_pcc)
    );

    ofd_tbl_step #(.PW(TPTR_W)) u_step (
        .ptr        (table_pointer),
        .mode       (d_step),
        .access_addr(t_access),
        .next_ptr   (t_next)
    );

    // ------------------------------------------------------------
    // instruction sequencing
    // ------------------------------------------------------------
    wire marked     = (word_in[15:12] == SECOND_MARK);
    wire take_first = wr_instr && !pending && fwd_two && !marked;
    wire lone_2nd   = wr_instr && !pending && fwd_two && marked;       // see RULE14
    wire bad_2nd    = wr_instr && pending && !marked;                  // see RULE14
    wire exec       = wr_instr && (pending ? marked : !fwd_two);
    wire is_call    = exec && (form == FM_CALL);
    wire is_ret     = exec && (form == FM_RET);
    wire [11:0] bank_addr = d_acc ? {bank_selector, d_f8} : {ACCESS_BANK, d_f8};  // see RULE1

    // ------------------------------------------------------------
    // register file and execution
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            first_word <= 16'h0000;
            last_word  <= 16'h0000;
            pending    <= 1'b0;
            form       <= 4'h0;
            pair_err   <= 1'b0;
            nop_q      <= 1'b0;
            exec_pulse <= 1'b0;
        end else begin
            exec_pulse <= exec;
            if (hit(wb_adr_i, OFS_FORM) && wb_sel_i[0] && !pending) begin
                form <= wb_dat_i[3:0];
            end
            if (wr_instr) begin
                last_word <= word_in;
                nop_q     <= lone_2nd;                                  // see RULE14
            end
            if (take_first) begin
                first_word <= word_in;
                pending    <= 1'b1;
            end else if (exec || bad_2nd) begin
                pending <= 1'b0;
            end
            if (bad_2nd) begin
                pair_err <= 1'b1;
            end else if (exec) begin
                pair_err <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            working_accumulator <= 8'h00;
            bank_selector       <= '0;
            status_flags        <= STAT_RESET;
            sh_acc              <= 8'h00;
            sh_bank             <= '0;
            sh_flags            <= STAT_RESET;
        end else if (is_call && d_fast) begin
            sh_acc   <= working_accumulator;                           // see RULE10
            sh_bank  <= bank_selector;
            sh_flags <= status_flags;
        end else if (is_ret && d_fast) begin
            working_accumulator <= sh_acc;                             // see RULE10
            bank_selector       <= sh_bank;
            status_flags        <= sh_flags;
        end else begin
            if (hit(wb_adr_i, OFS_WACC) && wb_sel_i[0]) begin
                working_accumulator <= wb_dat_i[7:0];
            end
            if (hit(wb_adr_i, OFS_BANK) && wb_sel_i[0]) begin
                bank_selector <= wb_dat_i[BANK_W-1:0];
            end
            if (hit(wb_adr_i, OFS_STAT) && wb_sel_i[0]) begin
                status_flags <= wb_dat_i[4:0];                         // see RULE13
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            table_pointer    <= '0;
            table_latch      <= 8'h00;
            indirect_pointer <= 12'h000;
            table_access     <= '0;
        end else begin
            if (exec && form == FM_TABLE) begin
                table_pointer <= t_next;                               // see RULE7
                table_access  <= t_access;
            end else if (hit(wb_adr_i, OFS_TPTR)) begin
                table_pointer <= TPTR_W'(merge({11'h000, table_pointer}, wb_dat_i, wb_sel_i));
            end
            if (hit(wb_adr_i, OFS_TLAT) && wb_sel_i[0]) begin
                table_latch <= wb_dat_i[7:0];                          // see RULE8
            end
            if (hit(wb_adr_i, OFS_PTR)) begin
                indirect_pointer <= 12'(merge({20'h00000, indirect_pointer}, wb_dat_i, wb_sel_i));
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            file_addr           <= 12'h000;
            bit_mask            <= 8'h00;
            to_file             <= 1'b0;
            ptr_sel_q           <= 2'h0;
            move_source_address <= 12'h000;
            move_target_address <= 12'h000;
            lit_q               <= 20'h00000;
            lit_w_q             <= LW_8;
            target_q            <= 21'h000000;
            rel_q               <= 1'b0;
            cycles              <= CYC_ONE;
        end else if (exec) begin
            file_addr <= bank_addr;                                    // see RULE1
            bit_mask  <= 8'h01 << d_bit;                               // see RULE2
            to_file   <= d_to_file;                                    // see RULE3
            ptr_sel_q <= d_ptr;                                        // see RULE4
            if (form == FM_IDXMOVE) begin
                move_source_address <= indirect_pointer + 12'(d_src_off); // see RULE12
                move_target_address <= indirect_pointer + 12'(d_dst_off);
            end else begin
                move_source_address <= d_src_adr;                      // see RULE5
                move_target_address <= d_dst_adr;
            end
            lit_q    <= d_lit;                                         // see RULE6
            lit_w_q  <= d_lit_w;
            target_q <= d_target;                                      // see RULE9
            rel_q    <= d_rel;
            cycles   <= (d_two || d_pcc) ? CYC_TWO : CYC_ONE;          // see RULE15
        end else if (lone_2nd) begin
            cycles <= CYC_ONE;
        end
    end

    // ------------------------------------------------------------
    // read back and acknowledge
    // ------------------------------------------------------------
    wire [31:0] rd_daddr = {8'h00, ptr_sel_q, 1'b0, to_file, bit_mask, file_addr};
    wire [31:0] rd_decst = {24'h000000, 3'(OSC_PER_CYC), cycles, pair_err, nop_q, pending};
    wire [7:0]  a        = wb_adr_i;
    wire [31:0] rd_mux   =
        (a == OFS_INSTR) ? {16'h0000, last_word} :
        (a == OFS_FORM)  ? {28'h0000000, form} :
        (a == OFS_WACC)  ? {24'h000000, working_accumulator} :
        (a == OFS_BANK)  ? 32'(bank_selector) :
        (a == OFS_STAT)  ? {27'h0000000, status_flags} :
        (a == OFS_TPTR)  ? {11'h000, table_pointer} :
        (a == OFS_TLAT)  ? {24'h000000, table_latch} :
        (a == OFS_PTR)   ? {20'h00000, indirect_pointer} :
        (a == OFS_DADDR) ? rd_daddr :
        (a == OFS_MOVE)  ? {4'h0, move_target_address, 4'h0, move_source_address} :
        (a == OFS_LIT)   ? {lit_w_q, 10'h000, lit_q} :
        (a == OFS_TGT)   ? {rel_q, 10'h000, target_q} :
        (a == OFS_DECST) ? rd_decst : 32'h00000000;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end else begin
            wb_ack_o <= bus_req;
            if (rd) begin
                wb_dat_o <= rd_mux;
            end
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    property p_quick_region;
        @(posedge clk) disable iff (!rst_n)
        exec && (form == FM_BYTE) && !d_acc |=> file_addr[11:8] == ACCESS_BANK;
    endproperty
    a_quick_region: assert property (p_quick_region)   // see RULE1
        else $error("quick region not selected");

    property p_bank_region;
        @(posedge clk) disable iff (!rst_n)
        exec && (form == FM_BIT) && d_acc |=> file_addr[11:8] == $past(bank_selector);
    endproperty
    a_bank_region: assert property (p_bank_region)     // see RULE1
        else $error("bank selector not used");

    property p_bit_mask;
        @(posedge clk) disable iff (!rst_n)
        exec |=> $onehot(bit_mask) && bit_mask == (8'h01 << $past(d_bit));
    endproperty
    a_bit_mask: assert property (p_bit_mask)           // see RULE2
        else $error("bit mask wrong");

    property p_dest;
        @(posedge clk) disable iff (!rst_n)
        exec |=> to_file == $past(w1[9]);
    endproperty
    a_dest: assert property (p_dest)                   // see RULE3
        else $error("destination select wrong");

    property p_postinc;
        @(posedge clk) disable iff (!rst_n)
        exec && form == FM_TABLE && d_step == TS_POSTINC
            |=> table_pointer == $past(table_pointer) + 21'h1
                && table_access == $past(table_pointer);
    endproperty
    a_postinc: assert property (p_postinc)             // see RULE7
        else $error("post increment wrong");

    property p_shadow_kept;
        @(posedge clk) disable iff (!rst_n)
        exec && (form == FM_CALL || form == FM_RET) && !d_fast
            |=> $stable(sh_acc) && $stable(sh_flags) && $stable(sh_bank);
    endproperty
    a_shadow_kept: assert property (p_shadow_kept)     // see RULE10
        else $error("shadow changed without fast bit");

    property p_bad_pair;
        @(posedge clk) disable iff (!rst_n)
        wr_instr && pending && !marked |=> !pending && pair_err && !exec_pulse;
    endproperty
    a_bad_pair: assert property (p_bad_pair)           // see RULE14
        else $error("unmarked second word accepted");

    property p_cycles;
        @(posedge clk) disable iff (!rst_n)
        exec && d_pcc |=> cycles == CYC_TWO ##1 wb_ack_o == 1'b0;
    endproperty
    a_cycles: assert property (p_cycles)               // see RULE15
        else $error("cycle count wrong");

    property p_ack_once;
        @(posedge clk) disable iff (!rst_n)
        wb_ack_o |=> !wb_ack_o;
    endproperty
    a_ack_once: assert property (p_ack_once)
        else $error("ack held too long");

    c_two_word: cover property (@(posedge clk) disable iff (!rst_n) take_first ##[1:20] exec);
    c_lone_2nd: cover property (@(posedge clk) disable iff (!rst_n) lone_2nd);
    c_fast_ret: cover property (@(posedge clk) disable iff (!rst_n) is_ret && d_fast);
    c_table:    cover property (@(posedge clk) disable iff (!rst_n) exec && form == FM_TABLE);

endmodule : ofd_top

// *** sim/ofd_prog_mem.sv ***
// program memory model: instruction words that the bench issues to the decoder
// assumes the bench sets the index and takes the word combinationally
`timescale 1ns/100ps
module ofd_prog_mem (
    // fetch
    input  wire logic [3:0]  addr,
    output logic      [15:0] word
);
    // ----------------------------------------
    // word store
    // ----------------------------------------
    // byte a=1 d=1, byte a=0 d=0, bit 7 banked, table post+/none/pre+,
    // move pair, broken second word, lone second word, table post-
    localparam logic [15:0] ROM [11] = '{16'h0334, 16'h0034, 16'h0F12, 16'h0001,
        16'h0000, 16'h0003, 16'h0ABC, 16'hF123, 16'h0123, 16'hF055, 16'h0002};
    // words at unused indices are always emitted as 0
    assign word = (addr < 4'hB) ? ROM[addr] : 16'h0000;
endmodule : ofd_prog_mem

// *** sim/operand_field_decoder_bench.sv ***
// bench for the operand field decoder: words go in over wishbone
// assumes the decoded outputs settle right after the ack edge
`timescale 1ns/100ps
module operand_field_decoder_bench;
    import ofd_pkg::*;
    logic        clk, rst_n, cyc, stb, we;
    logic [7:0]  adr, bit_mask;
    logic [31:0] dat, q, rdat;
    logic [3:0]  sel, pa;
    logic [15:0] word;
    logic [11:0] file_addr;
    logic [20:0] table_access;
    logic        ack, to_file, exec_pulse;
    int          err_count = 0, tests_run = 0, cycles = 0, pulses = 0;

    ofd_prog_mem pm (.addr(pa), .word(word));
    ofd_top dut (.clk(clk), .rst_n(rst_n), .wb_adr_i(adr), .wb_dat_i(dat),
        .wb_sel_i(sel), .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_dat_o(rdat), .wb_ack_o(ack), .file_addr(file_addr),
        .bit_mask(bit_mask), .to_file(to_file), .table_access(table_access),
        .exec_pulse(exec_pulse));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (exec_pulse === 1'b1) pulses++;
        if (cycles == 3000) begin
            err_count++;
            stop_test();
        end
    end
    // ----------------------------------------
    // bus and compare tasks
    // ----------------------------------------
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= d;
        do @(posedge clk); while (ack !== 1'b1);
        q = rdat;
        cyc <= 1'b0; stb <= 1'b0;
        #1;
    endtask : wb
    task automatic ex(input logic [3:0] i);
        pa = i;
        #1;
        wb(1'b1, OFS_INSTR, {16'h0000, word});
    endtask : ex
    task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            $display("mismatch %s expected %h seen %h", s, e, g);
            err_count++;
        end
    endtask : chk
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : stop_test
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_byte();
        wb(1'b1, OFS_FORM, 32'h0); wb(1'b1, OFS_BANK, 32'h5);
        ex(4'h0);
        chk("banked addr", 32'h534, file_addr);
        chk("to file", 32'h1, to_file);
        ex(4'h1);
        chk("quick addr", 32'h034, file_addr);
        chk("to acc", 32'h0, to_file);
        $display("test byte done");
    endtask : t_byte
    task automatic t_bit();
        wb(1'b1, OFS_FORM, 32'h1); ex(4'h2);
        chk("bit mask", 32'h80, bit_mask);
        chk("bit addr", 32'h512, file_addr);
        $display("test bit done");
    endtask : t_bit
    task automatic t_tbl();
        wb(1'b1, OFS_TPTR, 32'h1FFFFE); wb(1'b1, OFS_FORM, 32'h6);
        ex(4'h3); chk("post inc", 32'h1FFFFE, table_access);
        ex(4'h4); chk("no step", 32'h1FFFFF, table_access);
        ex(4'h5); chk("pre inc wrap", 32'h0, table_access);
        wb(1'b0, OFS_TPTR, 32'h0); chk("pointer", 32'h0, q);
        ex(4'hA); chk("post dec", 32'h0, table_access);
        wb(1'b0, OFS_TPTR, 32'h0); chk("pointer back", 32'h1FFFFF, q);
        wb(1'b1, OFS_TLAT, 32'hA5); wb(1'b0, OFS_TLAT, 32'h0);
        chk("latch", 32'hA5, q);
        $display("test table done");
    endtask : t_tbl
    task automatic t_move();
        int p;
        p = pulses;
        wb(1'b1, OFS_FORM, 32'h4); ex(4'h6); ex(4'h7);
        wb(1'b0, OFS_MOVE, 32'h0); chk("move", 32'h0123_0ABC, q);
        ex(4'h6); ex(4'h8);
        wb(1'b0, OFS_DECST, 32'h0); chk("pair err", 32'h1, {31'h0, q[2]});
        ex(4'h9);
        wb(1'b0, OFS_DECST, 32'h0); chk("lone nop", 32'h1, {31'h0, q[1]});
        wb(1'b0, 8'h3C, 32'h0); chk("unmapped", 32'h0, q);
        chk("exec pulses", 32'h1, pulses - p);
        $display("test move done");
    endtask : t_move
    task automatic t_ctl();
        wb(1'b1, OFS_WACC, 32'h5A); wb(1'b1, OFS_STAT, 32'h15);
        wb(1'b1, OFS_FORM, 32'hA); ex(4'h0); ex(4'h7);
        wb(1'b0, OFS_LIT, 32'h0); chk("call lit", 32'h8001_2334, q);
        wb(1'b0, OFS_TGT, 32'h0); chk("call target", 32'h0001_2334, q);
        wb(1'b0, OFS_DECST, 32'h0); chk("call decst", 32'h90, q);
        wb(1'b1, OFS_WACC, 32'h0); wb(1'b1, OFS_STAT, 32'h0); wb(1'b1, OFS_FORM, 32'hB);
        ex(4'h4); wb(1'b0, OFS_WACC, 32'h0); chk("slow ret", 32'h0, q);
        ex(4'h3); wb(1'b0, OFS_WACC, 32'h0); chk("fast ret", 32'h5A, q);
        wb(1'b0, OFS_STAT, 32'h0); chk("flags back", 32'h15, q);
        wb(1'b1, OFS_FORM, 32'h7); ex(4'h6);
        wb(1'b0, OFS_TGT, 32'h0); chk("rel8 target", 32'h801F_FFBC, q);
        wb(1'b1, OFS_FORM, 32'h3); ex(4'h6); ex(4'h7);
        wb(1'b0, OFS_LIT, 32'h0); chk("lit12", 32'h4000_0C23, q);
        wb(1'b1, OFS_FORM, 32'h5); wb(1'b1, OFS_PTR, 32'h100); ex(4'h6); ex(4'h7);
        wb(1'b0, OFS_MOVE, 32'h0); chk("idx move", 32'h0123_013C, q);
        $display("test control done");
    endtask : t_ctl

    initial begin
        rst_n = 1'b0; cyc = 1'b0; stb = 1'b0; we = 1'b0;
        adr = 8'h00; dat = 32'h0; sel = 4'hF; pa = 4'h0;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        t_byte();
        t_bit();
        t_tbl();
        t_move();
        t_ctl();
        stop_test();
    end
endmodule : operand_field_decoder_bench
